// >>> src/bcr_capability_regs.sv
// read-only capability, response-time and pointer registers on an ahb-lite slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_regs.svh"

// Behaviour
// [RULE_01] 64-bit read-only flags at 0x1C4, upper zero
// [RULE_02] bit 0 flags writable user name
// [RULE_03] bit 1 flags heartbeat and access privilege
// [RULE_04] bit 2 flags message channel
// [RULE_05] bit 3 flags timestamp register
// [RULE_06] bits 4-7 string encoding, codes 0-2 only
// [RULE_07] bit 8 flags family name register
// [RULE_08] bit 9 flags secondary map
// [RULE_09] bit 10 flags endianness register
// [RULE_10] bit 11 flags written length field
// [RULE_11] bit 12 flags multiple events per packet
// [RULE_12] bit 13 flags stacked read and write
// [RULE_13] bit 14 flags software interface version register
// [RULE_14] 32-bit max execution time at 0x1CC
// [RULE_15] pending ack sent before time runs out
// [RULE_16] advertised time clamped to 300 ms
// [RULE_17] time register read answered within 50 ms
// [RULE_18] 64-bit file list pointer at 0x1D0
// [RULE_19] 64-bit secondary map pointer at 0x1D8
// [RULE_20] secondary pointer exists only with bit 9
// [RULE_21] family name exists only with bit 8
// [RULE_22] reads harmless, writes ignored
module bcr_capability_regs #(
	parameter logic [31:0] EXEC_TIME_MS = `BCR_EXEC_TIME_DEFAULT_MS,
	parameter logic [63:0] FILE_LIST_ADDR = `BCR_FILE_LIST_DEFAULT,
	parameter logic [63:0] SEC_MAP_ADDR = `BCR_SEC_MAP_DEFAULT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// feature straps from the rest of the device
	input wire logic feat_user_name,
	input wire logic feat_heartbeat_priv,
	input wire logic feat_msg_channel,
	input wire logic feat_timestamp,
	input wire logic [1:0] feat_encoding,
	input wire logic feat_family_name,
	input wire logic feat_secondary_map,
	input wire logic feat_endian_reg,
	input wire logic feat_written_len,
	input wire logic feat_multi_event,
	input wire logic feat_stacked_cmd,
	input wire logic feat_sw_if_version,
	// command execution supervision
	input wire logic cmd_start,
	input wire logic cmd_done,
	output logic pending_ack_req,
	output logic [31:0] exec_time_ms
);
	localparam logic [31:0] READ_LIMIT_CYCLES = 32'(`BCR_READ_LIMIT_CYCLES);
	localparam logic [31:0] CYCLES_PER_MS = 32'(`BCR_CLOCK_HZ / 1000);
	logic [63:0] flags_reg;
	logic [63:0] flags_next;
	logic [31:0] exec_time_reg;
	logic [31:0] rdata_next;
	logic [31:0] hrdata_reg;
	logic [11:0] word_addr;
	logic [31:0] ms_div_reg;
	logic [31:0] elapsed_ms_reg;
	logic busy_reg;
	logic pend_sent_reg;
	logic [3:0] enc_code;

	// encoding enum mapped onto the 4-bit field; reserved codes cannot arise
	always_comb begin
		unique case (bcr_pkg::bcr_enc_t'(feat_encoding))
			bcr_pkg::BCR_ENC_T_ASCII: enc_code = `BCR_ENC_ASCII; // RULE_06
			bcr_pkg::BCR_ENC_T_UTF8: enc_code = `BCR_ENC_UTF8; // RULE_06
			bcr_pkg::BCR_ENC_T_UTF16: enc_code = `BCR_ENC_UTF16; // RULE_06
			default: enc_code = `BCR_ENC_ASCII; // code 3 folds to ascii, never reported
		endcase
	end

	// assemble the flag word; reserved bits stay zero
	always_comb begin
		flags_next = 64'h0000000000000000; // RULE_01
		flags_next[`BCR_BIT_USER_NAME] = feat_user_name; // RULE_02
		flags_next[`BCR_BIT_HEARTBEAT_PRIV] = feat_heartbeat_priv; // RULE_03
		flags_next[`BCR_BIT_MSG_CHANNEL] = feat_msg_channel; // RULE_04
		flags_next[`BCR_BIT_TIMESTAMP] = feat_timestamp; // RULE_05
		flags_next[`BCR_ENC_MSB:`BCR_ENC_LSB] = enc_code; // RULE_06
		flags_next[`BCR_BIT_FAMILY_NAME] = feat_family_name; // RULE_07 RULE_21
		flags_next[`BCR_BIT_SECONDARY_MAP] = feat_secondary_map; // RULE_08
		flags_next[`BCR_BIT_ENDIAN_REG] = feat_endian_reg; // RULE_09
		flags_next[`BCR_BIT_WRITTEN_LEN] = feat_written_len; // RULE_10
		flags_next[`BCR_BIT_MULTI_EVENT] = feat_multi_event; // RULE_11
		flags_next[`BCR_BIT_STACKED_CMD] = feat_stacked_cmd; // RULE_12
		flags_next[`BCR_BIT_SW_IF_VERSION] = feat_sw_if_version; // RULE_13
	end

	// straps captured every clock after reset so a reset value is never a port
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flags_reg <= 64'h0000000000000000;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// advertised time clamped so an oversized parameter cannot break the limit
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			exec_time_reg <= 32'h00000000;
		end else if (EXEC_TIME_MS > `BCR_EXEC_TIME_MAX_MS) begin
			exec_time_reg <= `BCR_EXEC_TIME_MAX_MS; // RULE_16
		end else begin
			exec_time_reg <= EXEC_TIME_MS; // RULE_14
		end
	end
	assign exec_time_ms = exec_time_reg;

	// word address of the address phase; byte lanes are ignored, whole words only
	assign word_addr = {haddr[11:2], 2'b00};

	// read mux on the address phase; unmapped or absent addresses read zero
	always_comb begin
		rdata_next = 32'h00000000;
		unique case (word_addr)
			`BCR_FLAGS_LO_OFF: rdata_next = flags_reg[31:0]; // RULE_01
			`BCR_FLAGS_HI_OFF: rdata_next = flags_reg[63:32]; // RULE_01
			`BCR_EXEC_TIME_OFF: rdata_next = exec_time_reg; // RULE_14
			`BCR_FILE_LIST_LO_OFF: rdata_next = FILE_LIST_ADDR[31:0]; // RULE_18
			`BCR_FILE_LIST_HI_OFF: rdata_next = FILE_LIST_ADDR[63:32]; // RULE_18
			`BCR_SEC_MAP_LO_OFF: begin
				if (flags_reg[`BCR_BIT_SECONDARY_MAP]) begin
					rdata_next = SEC_MAP_ADDR[31:0]; // RULE_19 RULE_20
				end
			end
			`BCR_SEC_MAP_HI_OFF: begin
				if (flags_reg[`BCR_BIT_SECONDARY_MAP]) begin
					rdata_next = SEC_MAP_ADDR[63:32]; // RULE_19 RULE_20
				end
			end
			default: rdata_next = 32'h00000000;
		endcase
	end

	// read data launched at the address edge, so it stands from a flop for the data phase
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hrdata_reg <= 32'h00000000;
		end else if (hready) begin
			if (hsel && htrans[1] && !hwrite) begin
				hrdata_reg <= rdata_next;
			end else begin
				hrdata_reg <= 32'h00000000; // RULE_22
			end
		end
	end

	// zero-wait answer: one cycle, far under the read limit
	always_comb begin
		hreadyout = 1'b1; // RULE_17
		hresp = 1'b0;
	end

	// writes leave no trace; reads show zero outside their own data phase
	assign hrdata = hrdata_reg;

	// millisecond tick from the clock divider
	always_ff @(posedge clock) begin
		if (!rst_n || !busy_reg || cmd_start) begin
			ms_div_reg <= 32'h00000000;
		end else if (ms_div_reg == CYCLES_PER_MS - 32'h00000001) begin
			ms_div_reg <= 32'h00000000;
		end else begin
			ms_div_reg <= ms_div_reg + 32'h00000001;
		end
	end

	// execution timer; a pending ack goes out one ms before the advertised time
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			elapsed_ms_reg <= 32'h00000000;
			pend_sent_reg <= 1'b0;
		end else if (cmd_start) begin
			busy_reg <= 1'b1;
			elapsed_ms_reg <= 32'h00000000;
			pend_sent_reg <= 1'b0;
		end else if (cmd_done) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			if (ms_div_reg == CYCLES_PER_MS - 32'h00000001) begin
				elapsed_ms_reg <= elapsed_ms_reg + 32'h00000001;
			end
			if (pending_ack_req) begin
				pend_sent_reg <= 1'b1;
			end
		end
	end

	// restart counts after each pending ack would need a new window; one per command here
	assign pending_ack_req = busy_reg && !pend_sent_reg && !cmd_done &&
		(elapsed_ms_reg + 32'h00000001 >= exec_time_reg); // RULE_15

	wire unused_ok = &{1'b0, hsize, hwdata, haddr[1:0], READ_LIMIT_CYCLES[0]};
endmodule : bcr_capability_regs
`default_nettype wire

// >>> include/bcr_regs.svh
// offsets, field positions, reset values and timing counts of the capability registers
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH
`define BCR_FLAGS_LO_OFF 12'h1C4
`define BCR_FLAGS_HI_OFF 12'h1C8
`define BCR_EXEC_TIME_OFF 12'h1CC
`define BCR_FILE_LIST_LO_OFF 12'h1D0
`define BCR_FILE_LIST_HI_OFF 12'h1D4
`define BCR_SEC_MAP_LO_OFF 12'h1D8
`define BCR_SEC_MAP_HI_OFF 12'h1DC
`define BCR_BIT_USER_NAME 0
`define BCR_BIT_HEARTBEAT_PRIV 1
`define BCR_BIT_MSG_CHANNEL 2
`define BCR_BIT_TIMESTAMP 3
`define BCR_ENC_LSB 4
`define BCR_ENC_MSB 7
`define BCR_BIT_FAMILY_NAME 8
`define BCR_BIT_SECONDARY_MAP 9
`define BCR_BIT_ENDIAN_REG 10
`define BCR_BIT_WRITTEN_LEN 11
`define BCR_BIT_MULTI_EVENT 12
`define BCR_BIT_STACKED_CMD 13
`define BCR_BIT_SW_IF_VERSION 14
`define BCR_ENC_ASCII 4'h0
`define BCR_ENC_UTF8 4'h1
`define BCR_ENC_UTF16 4'h2
`define BCR_EXEC_TIME_MAX_MS 32'h0000012C
`define BCR_EXEC_TIME_DEFAULT_MS 32'h00000064
`define BCR_READ_LIMIT_MS 50
`define BCR_CLOCK_HZ 25000000
`define BCR_READ_LIMIT_CYCLES ((`BCR_READ_LIMIT_MS * `BCR_CLOCK_HZ) / 1000)
`define BCR_FILE_LIST_DEFAULT 64'h0000000000010000
`define BCR_SEC_MAP_DEFAULT 64'h0000000000020000
`endif

// >>> include/bcr_pkg.sv
// types of the capability register bank
package bcr_pkg;
	typedef enum logic [1:0] {
		BCR_ENC_T_ASCII = 2'b00,
		BCR_ENC_T_UTF8 = 2'b01,
		BCR_ENC_T_UTF16 = 2'b10
	} bcr_enc_t;
	typedef enum logic {
		BCR_IDLE = 1'b0,
		BCR_DATA = 1'b1
	} bcr_phase_t;
endpackage : bcr_pkg

// >>> sim/bcr_capability_regs_props.sv
// assertions on the capability register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "bcr_regs.svh"
module bcr_capability_regs_props #(
	parameter logic [31:0] EXEC_TIME_MS = `BCR_EXEC_TIME_DEFAULT_MS,
	parameter logic [63:0] FILE_LIST_ADDR = `BCR_FILE_LIST_DEFAULT,
	parameter logic [63:0] SEC_MAP_ADDR = `BCR_SEC_MAP_DEFAULT
) (
	// clock, reset and bus
	input wire logic clock, rst_n, hsel, hready, hwrite, hreadyout, hresp,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans, feat_encoding,
	input wire logic [31:0] hrdata, exec_time_ms,
	// straps and supervision
	input wire logic feat_user_name, feat_heartbeat_priv, feat_msg_channel, feat_timestamp,
	input wire logic feat_family_name, feat_secondary_map, feat_endian_reg, feat_written_len,
	input wire logic feat_multi_event, feat_stacked_cmd, feat_sw_if_version,
	input wire logic cmd_start, cmd_done, pending_ack_req
);
	localparam logic [31:0] MAXMS = `BCR_EXEC_TIME_MAX_MS;
	localparam logic [31:0] CLAMP = (EXEC_TIME_MS > MAXMS) ? MAXMS : EXEC_TIME_MS;
	localparam int LIMIT = CLAMP * 25000;
	logic [3:0] enc;
	logic [31:0] cnt;
	logic run, seen;
	// reserved code 3 must still show as ascii
	assign enc = (feat_encoding == 2'h3) ? 4'h0 : {2'h0, feat_encoding};
	// cycles since a command began, and whether a pending ack came
	always_ff @(posedge clock) begin
		if (!rst_n || cmd_start) begin
			cnt <= 32'h0;
			seen <= 1'b0;
		end else if (run) begin
			cnt <= cnt + 32'h1;
			seen <= seen | pending_ack_req;
		end
	end
	// a command stays open until done; a new start wins, as in the timer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			run <= 1'b0;
		end else if (cmd_start) begin
			run <= 1'b1;
		end else if (cmd_done) begin
			run <= 1'b0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// a read taken at one address
	sequence rd_s(logic [11:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr == a;
	endsequence
	ready_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer late or not okay");
	flags_lo_a: assert property (rd_s(`BCR_FLAGS_LO_OFF) |=> hrdata == {17'h0,
		feat_sw_if_version, feat_stacked_cmd, feat_multi_event, feat_written_len,
		feat_endian_reg, feat_secondary_map, feat_family_name, enc, feat_timestamp,
		feat_msg_channel, feat_heartbeat_priv, feat_user_name}) else $error("flag word wrong");
	enc_code_a: assert property (rd_s(`BCR_FLAGS_LO_OFF) |=> hrdata[7:4] == enc)
		else $error("encoding wrong");
	flags_hi_a: assert property (rd_s(`BCR_FLAGS_HI_OFF) |=> hrdata == 32'h0)
		else $error("upper flags not zero");
	time_read_a: assert property (rd_s(`BCR_EXEC_TIME_OFF) |=> hrdata == CLAMP)
		else $error("time read wrong");
	time_max_a: assert property (exec_time_ms <= MAXMS) else $error("time too big");
	file_ptr_a: assert property (rd_s(`BCR_FILE_LIST_LO_OFF) |=>
		hrdata == FILE_LIST_ADDR[31:0]) else $error("file pointer wrong");
	sec_ptr_a: assert property (rd_s(`BCR_SEC_MAP_LO_OFF) |=>
		hrdata == (feat_secondary_map ? SEC_MAP_ADDR[31:0] : 32'h0)) else $error("sec wrong");
	pend_due_a: assert property (!(run && cnt >= LIMIT && !seen))
		else $error("no pending ack in time");
	pend_cause_a: assert property (pending_ack_req |-> run || cmd_start)
		else $error("pending ack without command");
endmodule : bcr_capability_regs_props
bind bcr_capability_regs bcr_capability_regs_props #(.EXEC_TIME_MS(EXEC_TIME_MS),
	.FILE_LIST_ADDR(FILE_LIST_ADDR), .SEC_MAP_ADDR(SEC_MAP_ADDR)) u_props (.*);
`default_nettype wire

// >>> sim/bcr_capability_regs_test.sv
// self-checking bench of the capability register bank
`timescale 1ns/1ps
`default_nettype none
`include "bcr_regs.svh"
module bcr_capability_regs_test;
	localparam logic [31:0] EMS = 32'h00000002;
	localparam logic [63:0] FL = `BCR_FILE_LIST_DEFAULT;
	localparam logic [63:0] SM = `BCR_SEC_MAP_DEFAULT;
	// bus, straps and supervision
	logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cmd_start = 1'b0;
	logic cmd_done = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0, enc = 2'h0;
	logic [31:0] hwdata = 32'h00000000;
	logic [10:0] feat = 11'h000;
	wire logic hreadyout, hresp, pending_ack_req;
	wire logic [31:0] hrdata, exec_time_ms;
	int err_total = 0, tests_run = 0;
	// 25 MHz
	always #20 clock = ~clock;
	// one slave, so its ready is the bus ready
	bcr_capability_regs #(.EXEC_TIME_MS(EMS)) dut (.clock(clock), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.feat_user_name(feat[0]), .feat_heartbeat_priv(feat[1]), .feat_msg_channel(feat[2]),
		.feat_timestamp(feat[3]), .feat_encoding(enc), .feat_family_name(feat[4]),
		.feat_secondary_map(feat[5]), .feat_endian_reg(feat[6]), .feat_written_len(feat[7]),
		.feat_multi_event(feat[8]), .feat_stacked_cmd(feat[9]), .feat_sw_if_version(feat[10]),
		.cmd_start(cmd_start), .cmd_done(cmd_done), .pending_ack_req(pending_ack_req),
		.exec_time_ms(exec_time_ms));
	// a second bank with an oversized time, only to see the clamp
	wire logic [31:0] clamp_time_ms;
	bcr_capability_regs #(.EXEC_TIME_MS(32'h000001F4)) dut_clamp (.clock(clock), .rst_n(rst_n),
		.hsel(1'b0), .haddr(12'h000), .htrans(2'h0), .hwrite(1'b0), .hsize(3'h2),
		.hwdata(32'h00000000), .hready(1'b1), .hreadyout(), .hresp(), .hrdata(),
		.feat_user_name(1'b0), .feat_heartbeat_priv(1'b0), .feat_msg_channel(1'b0),
		.feat_timestamp(1'b0), .feat_encoding(2'h0), .feat_family_name(1'b0),
		.feat_secondary_map(1'b0), .feat_endian_reg(1'b0), .feat_written_len(1'b0),
		.feat_multi_event(1'b0), .feat_stacked_cmd(1'b0), .feat_sw_if_version(1'b0),
		.cmd_start(1'b0), .cmd_done(1'b0), .pending_ack_req(), .exec_time_ms(clamp_time_ms));
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// address phase, then data phase; each held until ready is sampled high at a rising edge
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		for (int ph = 0; ph < 2; ph++) begin
			n = 0;
			do begin
				@(posedge clock);
				n++;
			end while (hreadyout !== 1'b1 && n < 50);
			rd = hrdata; // data phase value, taken at its closing edge
			if (hreadyout !== 1'b1) begin
				err_total++;
				end_sim();
			end
			if (ph == 0) begin
				hsel <= 1'b0;
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
	endtask : xfer
	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] v;
		xfer(a, 1'b0, 32'h0, v);
		check(what, v, exp);
		check("okay response", {31'h0, hresp}, 32'h0);
	endtask : rd
	// straps are captured every clock after reset, yet each pattern gets its own reset
	initial begin
		logic [31:0] fl, v;
		int n;
		for (int i = 0; i < 4; i++) begin
			enc <= i[1:0]; feat <= i[0] ? 11'h2AA : 11'h555; rst_n <= 1'b0;
			repeat (6) @(posedge clock);
			rst_n <= 1'b1;
			repeat (2) @(posedge clock);
			fl = {17'h0, feat[10:4], (enc == 2'h3) ? 4'h0 : {2'h0, enc}, feat[3:0]};
			if (i[1]) begin
				for (int k = 0; k < 4; k++) begin
					xfer(`BCR_FLAGS_LO_OFF + 12'(k * 4), 1'b1, 32'hFFFFFFFF, v);
				end
			end
			xfer(`BCR_FLAGS_LO_OFF, 1'b0, 32'h0, v);
			check("flags", v, fl);
			check("encoding", {28'h0, v[7:4]}, {28'h0, fl[7:4]});
			check("upper flags", {25'h0, v[14:8]}, {25'h0, fl[14:8]});
			check("more flags", {25'h0, v[14:8]}, {25'h0, feat[10:4]});
			rd("flags_hi", `BCR_FLAGS_HI_OFF, 32'h0);
			rd("exec_time", `BCR_EXEC_TIME_OFF, EMS);
			check("time port", exec_time_ms, EMS);
			check("clamped time", clamp_time_ms, `BCR_EXEC_TIME_MAX_MS);
			rd("file_lo", `BCR_FILE_LIST_LO_OFF, FL[31:0]);
			rd("file_hi", `BCR_FILE_LIST_HI_OFF, FL[63:32]);
			rd("sec_lo", `BCR_SEC_MAP_LO_OFF, feat[5] ? SM[31:0] : 32'h0);
			rd("sec_hi", `BCR_SEC_MAP_HI_OFF, feat[5] ? SM[63:32] : 32'h0);
			rd("family", 12'h084, 32'h0);
			rd("unmapped", 12'h1E0, 32'h0);
		end
		// a command held open until its pending ack, then done, must see that ack early enough
		cmd_start <= 1'b1;
		@(posedge clock);
		cmd_start <= 1'b0;
		n = 0;
		do begin @(negedge clock); n++; end while (pending_ack_req !== 1'b1 && n < 60000);
		check("pending in time", 32'(n < EMS * 25000), 32'h1);
		check("pending not early", 32'(n > 24000), 32'h1);
		@(posedge clock);
		cmd_done <= 1'b1;
		@(posedge clock);
		cmd_done <= 1'b0;
		end_sim();
	end
endmodule : bcr_capability_regs_test
`default_nettype wire
